// ### verilog/ms_timer_bank.sv
// Bank of millisecond timers with four trigger modes, gate and clear edge
//
// How it works
// - Each timer keeps a 32-bit elapsed time, readable at any moment.
// - Status bit and elapsed milliseconds are read back as separate words.
// - One-shot: rising trigger with gate on sets status, elapsed restarts at 0.
// - One-shot: reaching the constant clears status and holds elapsed value.
// - One-shot: trigger edges during timing are ignored.
// - Rising clear edge zeroes status and elapsed, deactivates the timer.
// - Gate low freezes elapsed time; counting resumes when gate returns high.
// - On-delay: rising trigger starts timing from 0, status stays low.
// - On-delay: at the constant status goes high until the trigger falls.
// - On-delay: early falling trigger ends timing, status low, count held.
// - Off-delay: rising trigger sets status high at once, no timing yet.
// - Off-delay: falling trigger starts timing; expiry drops status, holds count.
// - Off-delay: new rising edge before expiry keeps status, zeroes elapsed.
// - Pulse-limit: rising edge sets status, times; expiry clears status.
// - Pulse-limit: early falling trigger clears status and holds elapsed.
// - Constant is unsigned 32-bit milliseconds, loaded when triggered.
// - Bank holds 512 independent timers with their own inputs and outputs.
// - Gate level defaults to high until the scan drives it otherwise.
`timescale 1ns/1ps
`default_nettype none
module ms_timer_bank #(
   parameter int unsigned TICK_DIVISOR = ms_timer_pkg::TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ms_timer_pkg::ADDR_W-1:0] addr,
   input wire logic [ms_timer_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [ms_timer_pkg::DATA_W-1:0] rd_data,
   output logic bank_ready
);
   import ms_timer_pkg::*;

   typedef enum logic [1:0] {
      ST_INIT = 2'b00,
      ST_IDLE = 2'b01,
      ST_SWEEP = 2'b10
   } ctl_state_e;

   typedef struct packed {
      ctl_state_e fsm;
      logic [IDX_W-1:0] idx;
      logic tick_pend;
      logic [DATA_W-1:0] rd_data;
      logic ready;
   } ctl_s;

   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(TIMER_COUNT - 1);

   ctl_s ctl_reg;
   ctl_s ctl_next;

   // Per-timer state; memory, so it is filled by the init walk, not by reset
   timer_s bank [TIMER_COUNT];

   logic tick;
   logic ent_we;
   logic [IDX_W-1:0] ent_idx;
   timer_s ent_new;
   logic [IDX_W-1:0] bus_idx;
   logic [FIELD_W-1:0] bus_fld;

   assign bus_idx = addr[ADDR_W-1:FIELD_W];
   assign bus_fld = addr[FIELD_W-1:0];

   ms_tick_divider #(
      .DIVISOR(TICK_DIVISOR)
   ) u_tick (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick(tick)
   );

   // Begin a new activation in the given mode; constant sampled now
   function automatic timer_s start_timer(timer_s t, timer_mode_e m, logic sts);
      timer_s o;
      o = t;
      o.mode = m;
      o.status = sts;
      o.elapsed = WORD_RESET;
      o.constant = t.preset;
      o.run = (m != MODE_OFF_DELAY);
      return o;
   endfunction

   // Apply a new set of input levels written by the scan
   function automatic timer_s apply_control(timer_s t, logic [DATA_W-1:0] d);
      timer_s o;
      logic [3:0] trg;
      logic [3:0] rise;
      logic [3:0] fall;
      logic gate_new;
      logic clr_new;
      o = t;
      trg = d[CTL_TRIG_LSB +: 4];
      gate_new = d[CTL_GATE_BIT];
      clr_new = d[CTL_CLEAR_BIT];
      rise = trg & ~t.trig;
      fall = ~trg & t.trig;
      o.trig = trg;
      o.count_gate = gate_new;
      o.clear_edge_input = clr_new;
      if (clr_new && !t.clear_edge_input)
      begin
         // Clear edge wins over any trigger edge in the same write
         o.status = 1'b0;
         o.elapsed = WORD_RESET;
         o.run = 1'b0;
         o.mode = MODE_IDLE;
      end
      else
      begin
         // Falling edges act on the running mode only
         unique case (t.mode)
            MODE_ON_DELAY:
            begin
               if (fall[1])
               begin
                  o.run = 1'b0;
                  o.status = 1'b0;
               end
            end
            MODE_OFF_DELAY:
            begin
               if (fall[2] && !t.run && t.status)
               begin
                  o.run = 1'b1;
                  o.elapsed = WORD_RESET;
               end
            end
            MODE_PULSE_LIMIT:
            begin
               if (fall[3] && t.run)
               begin
                  o.run = 1'b0;
                  o.status = 1'b0;
               end
            end
            MODE_IDLE, MODE_ONE_SHOT:
            begin
               o.run = t.run;
            end
            default:
            begin
               o.mode = MODE_IDLE;
            end
         endcase
         // Rising edges start a timer that is not timing, or re-arm a timing off-delay one, gate high
         if (gate_new)
         begin
            if (rise[0] && !t.run)
               o = start_timer(o, MODE_ONE_SHOT, 1'b1);
            else if (rise[1] && !t.run)
               o = start_timer(o, MODE_ON_DELAY, 1'b0);
            else if (rise[2] && (!t.run || t.mode == MODE_OFF_DELAY))
               o = start_timer(o, MODE_OFF_DELAY, 1'b1);
            else if (rise[3] && !t.run)
               o = start_timer(o, MODE_PULSE_LIMIT, 1'b1);
         end
      end
      return o;
   endfunction

   // One millisecond step for one timer
   function automatic timer_s apply_tick(timer_s t);
      timer_s o;
      logic [DATA_W-1:0] inc;
      logic done;
      o = t;
      inc = t.elapsed + 32'h0000_0001;
      done = 1'b0;
      // Frozen while the gate is low; compare before stepping for constant 0
      if (t.run && t.count_gate)
      begin
         if (t.elapsed >= t.constant)
         begin
            done = 1'b1;
         end
         else
         begin
            o.elapsed = inc;
            done = (inc == t.constant);
         end
      end
      if (done)
      begin
         o.run = 1'b0;
         o.status = (t.mode == MODE_ON_DELAY);
      end
      return o;
   endfunction

   // Read-back word for one field
   function automatic logic [DATA_W-1:0] read_word(timer_s t, logic [FIELD_W-1:0] f);
      logic [DATA_W-1:0] w;
      w = WORD_RESET;
      unique case (f)
         FLD_CONTROL:
         begin
            w[STS_STATUS_BIT] = t.status;
            w[STS_RUN_BIT] = t.run;
            w[STS_MODE_LSB +: 3] = t.mode;
         end
         FLD_PRESET: w = t.preset;
         FLD_ELAPSED: w = t.elapsed;
         FLD_CONSTANT: w = t.constant;
      endcase
      return w;
   endfunction

   // Sequencer: init walk, bus writes, and tick sweeps over all timers
   always_comb
   begin
      ctl_next = ctl_reg;
      ent_we = 1'b0;
      ent_idx = ctl_reg.idx;
      ent_new = TIMER_RESET;
      if (rd_stb && ctl_reg.ready)
         ctl_next.rd_data = read_word(bank[bus_idx], bus_fld);
      unique case (ctl_reg.fsm)
         ST_INIT:
         begin
            // Scan writes are dropped until every entry holds its defaults
            ent_we = 1'b1;
            ent_new = TIMER_RESET;
            ctl_next.idx = ctl_reg.idx + 1'b1;
            if (ctl_reg.idx == LAST_IDX)
            begin
               ctl_next.fsm = ST_IDLE;
               ctl_next.ready = 1'b1;
            end
         end
         ST_IDLE, ST_SWEEP:
         begin
            if (wr_stb)
            begin
               // Bus write has priority; the sweep just waits one cycle
               ent_we = 1'b1;
               ent_idx = bus_idx;
               if (bus_fld == FLD_CONTROL)
                  ent_new = apply_control(bank[bus_idx], wr_data);
               else if (bus_fld == FLD_PRESET)
               begin
                  ent_new = bank[bus_idx];
                  ent_new.preset = wr_data;
               end
               else
               begin
                  ent_we = 1'b0;
               end
            end
            else if (ctl_reg.fsm == ST_SWEEP)
            begin
               ent_we = 1'b1;
               ent_new = apply_tick(bank[ctl_reg.idx]);
               ctl_next.idx = ctl_reg.idx + 1'b1;
               if (ctl_reg.idx == LAST_IDX)
                  ctl_next.fsm = ST_IDLE;
            end
            else if (ctl_reg.tick_pend)
            begin
               ctl_next.fsm = ST_SWEEP;
               ctl_next.idx = '0;
               ctl_next.tick_pend = 1'b0;
            end
         end
         default:
         begin
            ctl_next.fsm = ST_INIT;
         end
      endcase
      // A tick arriving as the pending flag is taken still counts
      if (tick && ctl_reg.ready)
         ctl_next.tick_pend = 1'b1;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctl_reg <= '{fsm: ST_INIT, idx: '0, tick_pend: 1'b0, rd_data: WORD_RESET, ready: 1'b0};
      else
         ctl_reg <= ctl_next;
   end

   // Timer memory, one entry written per cycle at most
   always_ff @(posedge sys_clk)
   begin
      if (ent_we)
         bank[ent_idx] <= ent_new;
   end

   assign rd_data = ctl_reg.rd_data;
   assign bank_ready = ctl_reg.ready;

endmodule
`default_nettype wire

// ### verilog/ms_timer_pkg.sv
// Shared constants, types and field layout of the millisecond timer bank
`default_nettype none
package ms_timer_pkg;

   // Bank geometry
   localparam int TIMER_COUNT = 512;
   localparam int IDX_W = 9;
   localparam int DATA_W = 32;
   localparam int FIELD_W = 2;
   localparam int ADDR_W = IDX_W + FIELD_W;

   // Timing: one millisecond tick from the 200 MHz system clock
   localparam longint CLK_FREQ_HZ = 200_000_000;
   localparam longint TICK_PERIOD_MS = 1;
   localparam int TICK_CYCLES = int'((CLK_FREQ_HZ * TICK_PERIOD_MS) / 1000);

   // Field select in the low address bits
   localparam logic [FIELD_W-1:0] FLD_CONTROL = 2'h0;
   localparam logic [FIELD_W-1:0] FLD_PRESET = 2'h1;
   localparam logic [FIELD_W-1:0] FLD_ELAPSED = 2'h2;
   localparam logic [FIELD_W-1:0] FLD_CONSTANT = 2'h3;

   // Control word written by the scan (input levels)
   localparam int CTL_GATE_BIT = 0;
   localparam int CTL_CLEAR_BIT = 1;
   localparam int CTL_TRIG_LSB = 2;

   // Status word read back
   localparam int STS_STATUS_BIT = 0;
   localparam int STS_RUN_BIT = 1;
   localparam int STS_MODE_LSB = 2;

   // Reset values
   localparam logic GATE_RESET = 1'b1;
   localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      MODE_IDLE = 3'b000,
      MODE_ONE_SHOT = 3'b001,
      MODE_ON_DELAY = 3'b010,
      MODE_OFF_DELAY = 3'b011,
      MODE_PULSE_LIMIT = 3'b100
   } timer_mode_e;

   // One timer's complete state
   typedef struct packed {
      logic [DATA_W-1:0] elapsed;
      logic [DATA_W-1:0] preset;
      logic [DATA_W-1:0] constant;
      timer_mode_e mode;
      logic status;
      logic run;
      logic count_gate;
      logic clear_edge_input;
      logic [3:0] trig;
   } timer_s;

   localparam timer_s TIMER_RESET = '{
      elapsed: WORD_RESET,
      preset: WORD_RESET,
      constant: WORD_RESET,
      mode: MODE_IDLE,
      status: 1'b0,
      run: 1'b0,
      count_gate: GATE_RESET,
      clear_edge_input: 1'b0,
      trig: 4'h0
   };

endpackage
`default_nettype wire

// ### verilog/ms_tick_divider.sv
// Divider that makes a one-cycle millisecond enable from the system clock
`timescale 1ns/1ps
`default_nettype none
module ms_tick_divider #(
   parameter int unsigned DIVISOR = ms_timer_pkg::TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   output logic tick
);
   import ms_timer_pkg::*;

   typedef struct packed {
      logic [31:0] count;
      logic tick;
   } div_s;

   div_s div_reg;
   div_s div_next;

   // Count down to the end of the period, pulse once
   always_comb
   begin
      div_next = div_reg;
      div_next.tick = 1'b0;
      if (div_reg.count == 32'h0000_0000)
      begin
         div_next.count = DIVISOR - 32'h0000_0001;
         div_next.tick = 1'b1;
      end
      else
      begin
         div_next.count = div_reg.count - 32'h0000_0001;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         div_reg <= '0;
      else
         div_reg <= div_next;
   end

   assign tick = div_reg.tick;

endmodule
`default_nettype wire

// ### tb/ms_timer_properties.sv
// Port-level properties of the timer bank, watching timer 0 through its control word
`timescale 1ns/1ps
`default_nettype none
module ms_timer_props #(
   parameter int unsigned TICK_DIVISOR = ms_timer_pkg::TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ms_timer_pkg::ADDR_W-1:0] addr,
   input wire logic [ms_timer_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [ms_timer_pkg::DATA_W-1:0] rd_data,
   input wire logic bank_ready
);
   import ms_timer_pkg::*;
   localparam logic [ADDR_W-1:0] A_CTL = ADDR_W'(FLD_CONTROL);
   localparam logic [ADDR_W-1:0] A_ELA = ADDR_W'(FLD_ELAPSED);
   logic [5:0] ctl_reg;
   logic [DATA_W-1:0] pre_reg;
   wire logic wctl = wr_stb && bank_ready && addr == A_CTL;
   wire logic [5:0] rise = wr_data[5:0] & ~ctl_reg;
   // Preset above 1 keeps a tick from finishing the timer before the read
   wire logic go = wctl && wr_data[0] && !rise[1] && pre_reg > 32'h1;
   wire logic rdctl = rd_stb && addr == A_CTL;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Stored levels of timer 0, so edges are judged as the bank judges them
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl_reg <= 6'h01;
         pre_reg <= '0;
      end
      else
      begin
         if (wctl)
            ctl_reg <= wr_data[5:0];
         if (wr_stb && bank_ready && addr == ADDR_W'(FLD_PRESET))
            pre_reg <= wr_data;
      end
   end
   // The scan's read follows its write two edges later, one idle cycle between strobes
   a_ready_holds: assert property (bank_ready |=> bank_ready)
      else $error("bank ready dropped");
   a_idle_read_zero: assert property (!bank_ready |-> rd_data == '0)
      else $error("read data before ready");
   a_read_holds: assert property (!$past(rd_stb) |-> $stable(rd_data))
      else $error("read data moved without a read");
   a_one_shot_sets: assert property (go && rise[2] ##2 rdctl |=> rd_data[1:0] == 2'b11)
      else $error("one-shot start wrong");
   a_clear_status: assert property (wctl && rise[1] ##2 rdctl |=> rd_data[1:0] == 2'b00)
      else $error("clear left status");
   a_clear_elapsed: assert property (wctl && rise[1] ##2 rd_stb && addr == A_ELA
      |=> rd_data == '0)
      else $error("clear left elapsed");
   a_on_delay_wait: assert property (go && rise[3:2] == 2'b10 ##2 rdctl
      |=> rd_data[1:0] == 2'b10)
      else $error("on-delay start wrong");
   a_off_delay_set: assert property (go && rise[4:2] == 3'b100 ##2 rdctl
      |=> rd_data[1:0] == 2'b01)
      else $error("off-delay rise wrong");
   a_pulse_start: assert property (go && rise[5:2] == 4'b1000 ##2 rdctl
      |=> rd_data[1:0] == 2'b11)
      else $error("pulse-limit start wrong");
   c_one_shot: cover property (go && rise[2]);
   c_clear: cover property (wctl && rise[1]);
   c_off_delay: cover property (go && rise[4:2] == 3'b100);
endmodule
`default_nettype wire

// ### tb/scan_master.sv
// Scan-side master driving the timer bank's register port
`timescale 1ns/1ps
`default_nettype none
module scan_master (
   input wire logic sys_clk,
   output logic [ms_timer_pkg::ADDR_W-1:0] addr,
   output logic [ms_timer_pkg::DATA_W-1:0] wr_data,
   output logic wr_stb,
   output logic rd_stb
);
   import ms_timer_pkg::*;
   // Quiet bus from time zero
   initial
   begin
      addr = '0;
      wr_data = '0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end
   // One-cycle strobes launched after an edge; stale data is inverted
   task automatic wr(input logic [IDX_W-1:0] i, input logic [FIELD_W-1:0] f,
      input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      addr <= {i, f};
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
      wr_data <= ~d;
   endtask
   task automatic rd(input logic [IDX_W-1:0] i, input logic [FIELD_W-1:0] f);
      @(posedge sys_clk);
      addr <= {i, f};
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the millisecond timer bank
`timescale 1ns/1ps
`default_nettype none
`define CMP(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
   import ms_timer_pkg::*;
   localparam int TD = 1024;
   localparam int WT = 5 * TD;
   localparam logic [DATA_W-1:0] SM = 32'h3;
   localparam logic [DATA_W-1:0] FM = 32'h1F;
   logic sys_clk;
   logic rst_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wr_data;
   logic wr_stb;
   logic rd_stb;
   logic [DATA_W-1:0] rd_data;
   logic bank_ready;
   logic rd_seen;
   logic [2*DATA_W-1:0] exp_q[$];
   logic [2*DATA_W-1:0] note;
   logic [31:0] seed;
   logic [DATA_W-1:0] p;
   int checks;
   int miscompares;
   ms_timer_bank #(.TICK_DIVISOR(TD)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
      .bank_ready(bank_ready));
   scan_master i_scan (.sys_clk(sys_clk), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
      .rd_stb(rd_stb));
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic chk(input logic [IDX_W-1:0] i, input logic [FIELD_W-1:0] f,
      input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] m);
      exp_q.push_back({m, e & m});
      i_scan.rd(i, f);
   endtask
   // Shorthands for timer 0
   task automatic c0(input logic [DATA_W-1:0] d);
      i_scan.wr('0, FLD_CONTROL, d);
   endtask
   task automatic s0(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] m);
      chk('0, FLD_CONTROL, e, m);
   endtask
   task automatic e0(input logic [DATA_W-1:0] e);
      chk('0, FLD_ELAPSED, e, '1);
   endtask
   // Read answers land one cycle after the strobe; judged at the falling edge
   always @(posedge sys_clk) rd_seen <= rd_stb;
   always @(negedge sys_clk)
   begin
      if (rd_seen === 1'b1)
      begin
         note = exp_q.pop_front();
         `CMP(rd_data & note[63:32], note[31:0])
      end
   end
   initial
   begin
      repeat (90000) @(posedge sys_clk);
      miscompares++;
      wrap_up();
   end
   initial
   begin
      rst_n = 1'b0;
      checks = 0;
      miscompares = 0;
      seed = 32'h58;
      idle(8);
      rst_n <= 1'b1;
      for (int n = 0; n < 2000 && bank_ready !== 1'b1; n++)
         @(posedge sys_clk);
      if (bank_ready !== 1'b1)
      begin
         miscompares++;
         wrap_up();
      end
      // One-shot; a late re-trigger must not restart it
      i_scan.wr('0, FLD_PRESET, 32'h3);
      c0(32'h5);
      s0(32'h07, FM);
      idle(2 * TD);
      c0(32'h1);
      c0(32'h5);
      idle(1900);
      s0(32'h0, SM);
      e0(32'h3);
      chk('0, FLD_CONSTANT, 32'h3, '1);
      c0(32'h3);
      e0(32'h0);
      s0(32'h0, SM);
      // On-delay: normal expiry, then an early fall
      c0(32'h1);
      c0(32'h9);
      s0(32'h0A, FM);
      idle(WT);
      s0(32'h1, SM);
      e0(32'h3);
      c0(32'h1);
      s0(32'h0, 32'h1);
      i_scan.wr('0, FLD_PRESET, 32'h2);
      c0(32'h9);
      c0(32'h1);
      idle(WT);
      s0(32'h0, SM);
      // Off-delay; the re-rise comes after one tick, so zeroing is visible
      c0(32'h11);
      s0(32'h0D, FM);
      c0(32'h1);
      idle(1000);
      c0(32'h11);
      idle(200);
      s0(32'h1, SM);
      e0(32'h0);
      c0(32'h1);
      idle(WT);
      s0(32'h0, SM);
      e0(32'h2);
      // Pulse-limit: expiry, then an early fall after two ticks
      c0(32'h21);
      s0(32'h13, FM);
      idle(WT);
      s0(32'h0, SM);
      e0(32'h2);
      c0(32'h1);
      i_scan.wr('0, FLD_PRESET, 32'h32);
      c0(32'h21);
      idle(1500);
      c0(32'h1);
      s0(32'h0, SM);
      e0(32'h2);
      // Gate low freezes an on-delay timer
      i_scan.wr('0, FLD_PRESET, 32'h3);
      c0(32'h9);
      c0(32'h8);
      idle(8000);
      s0(32'h0, 32'h1);
      e0(32'h0);
      c0(32'h9);
      idle(WT);
      s0(32'h1, SM);
      // Clear a finished on-delay timer whose status is high
      c0(32'h3);
      s0(32'h0, SM);
      // Random timers and constants; elapsed writes are refused
      for (int k = 0; k < 4; k++)
      begin
         seed = lfsr(seed);
         p = lfsr(seed) | 32'h1000;
         i_scan.wr(seed[8:0] | 9'h001, FLD_CONTROL, 32'h1);
         i_scan.wr(seed[8:0] | 9'h001, FLD_PRESET, p);
         i_scan.wr(seed[8:0] | 9'h001, FLD_CONTROL, 32'h5);
         chk(seed[8:0] | 9'h001, FLD_CONTROL, 32'h3, SM);
         chk(seed[8:0] | 9'h001, FLD_CONSTANT, p, '1);
         chk(seed[8:0] | 9'h001, FLD_PRESET, p, '1);
         i_scan.wr(seed[8:0] | 9'h001, FLD_CONTROL, 32'h3);
         i_scan.wr(seed[8:0] | 9'h001, FLD_ELAPSED, p);
         chk(seed[8:0] | 9'h001, FLD_ELAPSED, 32'h0, '1);
      end
      idle(4);
      wrap_up();
   end
endmodule
bind ms_timer_bank ms_timer_props #(.TICK_DIVISOR(TICK_DIVISOR)) i_props (.sys_clk(sys_clk),
   .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
   .rd_data(rd_data), .bank_ready(bank_ready));
`default_nettype wire
